// [sccs_clock_ctrl.sv]
// system clock source select, divider and internal oscillator control
module sccs_clock_ctrl #(
	parameter logic [6:0] TRIM_RESET = sccs_pkg::TRIM_RESET
) (
	input  wire logic       core_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic [7:0] sfr_addr_i,
	input  wire logic       sfr_wr_i,
	input  wire logic [7:0] sfr_wdata_i,
	input  wire logic       sfr_rd_i,
	input  wire logic       ext_osc_tick_i,
	output logic [7:0]      sfr_rdata_o,
	output logic            system_clock_out_o,
	output logic            clock_source_o
);

	typedef struct packed {
		logic [2:0]        system_divider_field;
		logic [2:0]        clock_source_field;
		logic [6:0]        osc_period_trim;
		logic [1:0]        internal_postscale_field;
		logic              spread_spectrum_enable;
		logic [2:0]        act_div;
		logic              act_src;
		logic              divider_applied_flag;
		sccs_pkg::sccs_sw_t sw;
		logic              seen_int;
		logic              seen_ext;
		logic [2:0]        post_cnt;
		logic [6:0]        div_cnt;
		logic              sys_tick;
		logic [7:0]        rdata;
	} sccs_state_t;

	sccs_state_t s_ff;
	sccs_state_t nxt_s;
	logic        osc_tick;
	logic        int_src_tick;
	logic        src_tick;
	logic        want_src;

	// ************************************************
	// helpers
	// ************************************************
	function automatic logic [2:0] post_limit(input logic [1:0] code);
		post_limit = 3'h7 >> code;
	endfunction : post_limit

	function automatic logic [6:0] div_limit(input logic [2:0] code);
		logic [7:0] ratio;
		ratio = 8'h01 << code;
		div_limit = 7'(ratio - 8'h01);
	endfunction : div_limit

	// ************************************************
	// internal oscillator
	// ************************************************
	sccs_int_osc u_osc (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.trim_i     (s_ff.osc_period_trim),
		.sse_i      (s_ff.spread_spectrum_enable),
		.tick_o     (osc_tick)
	);

	// ************************************************
	// next state
	// ************************************************
	always_comb begin
		nxt_s = s_ff;
		nxt_s.sys_tick = 1'b0;
		int_src_tick = 1'b0;
		// >= so a larger code (smaller limit) written mid-count still wraps
		if (osc_tick) begin
			if (s_ff.post_cnt >= post_limit(s_ff.internal_postscale_field)) begin
				nxt_s.post_cnt = 3'h0;
				int_src_tick = 1'b1;
			end else begin
				nxt_s.post_cnt = s_ff.post_cnt + 3'h1;
			end
		end
		src_tick = s_ff.act_src ? ext_osc_tick_i : int_src_tick;

		if (sfr_wr_i) begin
			case (sfr_addr_i)
				sccs_pkg::ADDR_CLK_SRC_DIV: begin
					nxt_s.system_divider_field = sfr_wdata_i[sccs_pkg::DIV_LSB +: 3];
					nxt_s.clock_source_field = sfr_wdata_i[sccs_pkg::SRC_LSB +: 3];
					if (sfr_wdata_i[sccs_pkg::DIV_LSB +: 3] != s_ff.act_div) begin
						nxt_s.divider_applied_flag = 1'b0;
					end
				end
				sccs_pkg::ADDR_OSC_CTL: begin
					nxt_s.spread_spectrum_enable = sfr_wdata_i[sccs_pkg::SSE_BIT];
					nxt_s.internal_postscale_field = sfr_wdata_i[sccs_pkg::POST_LSB +: 2];
				end
				sccs_pkg::ADDR_OSC_TRIM: begin
					nxt_s.osc_period_trim = sfr_wdata_i[6:0];
				end
				default: begin
				end
			endcase
		end

		// reserved codes leave the running source alone
		case (nxt_s.clock_source_field)
			sccs_pkg::SRC_INT: want_src = 1'b0;
			sccs_pkg::SRC_EXT: want_src = 1'b1;
			default:           want_src = s_ff.act_src;
		endcase

		// both oscillators must tick once, so the wait spans the slower
		case (s_ff.sw)
			sccs_pkg::SW_IDLE: begin
				if (want_src != s_ff.act_src) begin
					nxt_s.sw = sccs_pkg::SW_WAIT;
					nxt_s.seen_int = 1'b0;
					nxt_s.seen_ext = 1'b0;
				end
			end
			sccs_pkg::SW_WAIT: begin
				nxt_s.seen_int = s_ff.seen_int | int_src_tick;
				nxt_s.seen_ext = s_ff.seen_ext | ext_osc_tick_i;
				if (want_src == s_ff.act_src) begin
					nxt_s.sw = sccs_pkg::SW_IDLE;
				end
			end
			default: nxt_s.sw = sccs_pkg::SW_IDLE;
		endcase

		if (src_tick) begin
			if (s_ff.div_cnt >= div_limit(s_ff.act_div)) begin
				// period boundary: only here may ratio or source move
				nxt_s.div_cnt = 7'h00;
				nxt_s.sys_tick = 1'b1;
				nxt_s.act_div = nxt_s.system_divider_field;
				nxt_s.divider_applied_flag = 1'b1;
				if (s_ff.sw == sccs_pkg::SW_WAIT && nxt_s.seen_int
					&& nxt_s.seen_ext && want_src != s_ff.act_src) begin
					nxt_s.act_src = want_src;
					nxt_s.sw = sccs_pkg::SW_IDLE;
				end
			end else begin
				nxt_s.div_cnt = s_ff.div_cnt + 7'h01;
			end
		end

		if (sfr_rd_i) begin
			case (sfr_addr_i)
				sccs_pkg::ADDR_CLK_SRC_DIV: nxt_s.rdata = {s_ff.divider_applied_flag,
					s_ff.system_divider_field, 1'b0, s_ff.clock_source_field};
				sccs_pkg::ADDR_OSC_CTL: nxt_s.rdata = {4'h0, s_ff.spread_spectrum_enable,
					1'b0, s_ff.internal_postscale_field};
				sccs_pkg::ADDR_OSC_TRIM: nxt_s.rdata = {1'b0, s_ff.osc_period_trim};
				default: nxt_s.rdata = 8'h00;
			endcase
		end
	end

	// ************************************************
	// state register
	// ************************************************
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			s_ff <= '0;
			s_ff.system_divider_field <= sccs_pkg::DIV_RST;
			s_ff.clock_source_field <= sccs_pkg::SRC_RST;
			s_ff.internal_postscale_field <= sccs_pkg::POST_RST;
			s_ff.spread_spectrum_enable <= sccs_pkg::SSE_RST;
			s_ff.osc_period_trim <= TRIM_RESET;
			s_ff.sw <= sccs_pkg::SW_IDLE;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign sfr_rdata_o = s_ff.rdata;
	assign system_clock_out_o = s_ff.sys_tick;
	assign clock_source_o = s_ff.act_src;

	// ************************************************
	// checks
	// ************************************************
	logic [7:0] pend_cnt_ff;
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i || s_ff.divider_applied_flag) begin
			pend_cnt_ff <= 8'h00;
		end else if (src_tick && pend_cnt_ff != 8'hFF) begin
			pend_cnt_ff <= pend_cnt_ff + 8'h01;
		end
	end

	// source ticks in the period that the last system pulse closed
	logic [7:0] per_ticks_ff;
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			per_ticks_ff <= 8'h00;
		end else if (s_ff.sys_tick) begin
			per_ticks_ff <= {7'h00, src_tick};
		end else if (src_tick && per_ticks_ff != 8'hFF) begin
			per_ticks_ff <= per_ticks_ff + 8'h01;
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	a_reset_state: assert property ($past(sys_rst_i) |-> s_ff.act_src == 1'b0
		&& s_ff.system_divider_field == 3'h0 && s_ff.clock_source_field == 3'h0
		&& s_ff.internal_postscale_field == 2'h0)
		else $error("reset did not clear clock select state");
	a_bit3_zero: assert property (sfr_rd_i && sfr_addr_i == 8'hA9
		|=> sfr_rdata_o[3] == 1'b0)
		else $error("select register bit 3 read nonzero");
	a_rdy_readback: assert property (sfr_rd_i && sfr_addr_i == 8'hA9
		|=> sfr_rdata_o[7] == $past(s_ff.divider_applied_flag))
		else $error("ready flag read wrong");
	a_rdy_applied: assert property (s_ff.divider_applied_flag
		|-> s_ff.act_div == s_ff.system_divider_field)
		else $error("ready set while ratio not applied");
	a_div_bound: assert property (pend_cnt_ff <= 8'd128)
		else $error("divide change not applied within 128 cycles");
	a_div_edge: assert property ($changed(s_ff.act_div)
		|-> s_ff.sys_tick && s_ff.div_cnt == 7'h00)
		else $error("ratio changed off a period boundary");
	a_src_edge: assert property ($changed(s_ff.act_src) |-> s_ff.sys_tick
		&& $past(s_ff.sw) == sccs_pkg::SW_WAIT)
		else $error("source switched without wait or off boundary");
	a_div_ratio: assert property (s_ff.sys_tick
		|-> per_ticks_ff == 8'(8'h01 << $past(s_ff.act_div)))
		else $error("system period not the selected ratio");

endmodule : sccs_clock_ctrl

// [sccs_int_osc.sv]
// internal oscillator model: trimmed period with spread spectrum dithering
module sccs_int_osc #(
	parameter logic [7:0] MIN_PERIOD = 8'(sccs_pkg::OSC_MIN_CYC),
	parameter logic [7:0] SS_STEP    = 8'h01
) (
	input  wire logic       core_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic [6:0] trim_i,
	input  wire logic       sse_i,
	output logic            tick_o
);

	typedef struct packed {
		logic [7:0] per_cnt;
		logic [4:0] seg_cnt;
		logic [3:0] phase;
		logic       tick;
	} sccs_osc_t;

	sccs_osc_t s_ff;
	sccs_osc_t nxt_s;
	logic [7:0] period;

	// triangle offset in steps, -3..+3
	function automatic logic [7:0] tri_off(input logic [3:0] p);
		if (p <= 4'h3) begin
			tri_off = {4'h0, p};
		end else if (p <= 4'h9) begin
			tri_off = 8'h06 - {4'h0, p};
		end else begin
			tri_off = {4'h0, p} - 8'h0C;
		end
	endfunction : tri_off

	always_comb begin
		// larger trim means longer period, zero is fastest
		period = MIN_PERIOD + {1'b0, trim_i} + 8'(tri_off(s_ff.phase) * SS_STEP);
		nxt_s = s_ff;
		nxt_s.tick = 1'b0;
		if (s_ff.per_cnt >= period - 8'h01) begin
			nxt_s.per_cnt = 8'h00;
			nxt_s.tick = 1'b1;
			if (s_ff.seg_cnt == 5'(sccs_pkg::SS_STEP_TICKS - 1)) begin
				nxt_s.seg_cnt = 5'h00;
				if (s_ff.phase == 4'(sccs_pkg::SS_PHASES - 1)) begin
					nxt_s.phase = 4'h0;
				end else begin
					nxt_s.phase = s_ff.phase + 4'h1;
				end
			end else begin
				nxt_s.seg_cnt = s_ff.seg_cnt + 5'h01;
			end
		end else begin
			nxt_s.per_cnt = s_ff.per_cnt + 8'h01;
		end
		if (!sse_i) begin
			nxt_s.seg_cnt = 5'h00;
			nxt_s.phase = 4'h0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign tick_o = s_ff.tick;

	a_sse_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		!sse_i |=> s_ff.phase == 4'h0)
		else $error("dither phase moved while spread spectrum off");

	a_step_every: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		$changed(s_ff.phase) && $past(sse_i)
		|-> $past(s_ff.seg_cnt) == 5'h1F && s_ff.tick)
		else $error("dither step not on 32nd oscillator tick");

	a_wave_wrap: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		$changed(s_ff.phase) && s_ff.phase == 4'h0 && $past(sse_i)
		|-> $past(s_ff.phase) == 4'hB)
		else $error("triangle wave not 12 steps long");

endmodule : sccs_int_osc

// [sccs_pkg.sv]
// constants and types shared by the system clock select block
package sccs_pkg;

	// ************************************************
	// register addresses
	// ************************************************
	localparam logic [7:0] ADDR_CLK_SRC_DIV = 8'hA9;
	localparam logic [7:0] ADDR_OSC_CTL     = 8'hB2;
	localparam logic [7:0] ADDR_OSC_TRIM    = 8'hB3;

	// ************************************************
	// field positions
	// ************************************************
	localparam int unsigned RDY_BIT  = 7;
	localparam int unsigned DIV_LSB  = 4;
	localparam int unsigned ZERO_BIT = 3;
	localparam int unsigned SRC_LSB  = 0;
	localparam int unsigned SSE_BIT  = 3;
	localparam int unsigned POST_LSB = 0;

	// ************************************************
	// reset values and encodings
	// ************************************************
	localparam logic [2:0] DIV_RST    = 3'h0;
	localparam logic [2:0] SRC_RST    = 3'h0;
	localparam logic [2:0] SRC_INT    = 3'h0;
	localparam logic [2:0] SRC_EXT    = 3'h1;
	localparam logic [1:0] POST_RST   = 2'h0;
	localparam logic       SSE_RST    = 1'b0;
	localparam logic [6:0] TRIM_RESET = 7'h06;

	// ************************************************
	// timing
	// ************************************************
	localparam int unsigned DIV_MAX_RATIO = 128;
	localparam int unsigned SS_STEP_TICKS = 32;
	localparam int unsigned SS_WAVE_TICKS = 384;
	localparam int unsigned SS_PHASES     = SS_WAVE_TICKS / SS_STEP_TICKS;
	localparam int unsigned CORE_KHZ      = 250000;
	localparam int unsigned OSC_KHZ       = 24500;
	localparam int unsigned OSC_NOM_CYC   = CORE_KHZ / OSC_KHZ;
	localparam int unsigned OSC_MIN_CYC   = OSC_NOM_CYC - 32'(TRIM_RESET);

	typedef enum logic [0:0] {
		SW_IDLE = 1'b0,
		SW_WAIT = 1'b1
	} sccs_sw_t;

endpackage : sccs_pkg

// [tb.sv]
// self-checking bench for the system clock select and oscillator control
module tb;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [7:0] A_SEL = sccs_pkg::ADDR_CLK_SRC_DIV;
	localparam logic [7:0] A_CTL = sccs_pkg::ADDR_OSC_CTL;
	localparam logic [7:0] A_TRM = sccs_pkg::ADDR_OSC_TRIM;
	localparam int NOM = sccs_pkg::OSC_MIN_CYC + sccs_pkg::TRIM_RESET;

	logic        core_clk_i     = 1'b0;
	logic        sys_rst_i      = 1'b1;
	logic [7:0]  sfr_addr_i     = 8'h00;
	logic        sfr_wr_i       = 1'b0;
	logic [7:0]  sfr_wdata_i    = 8'h00;
	logic        sfr_rd_i       = 1'b0;
	logic        ext_osc_tick_i = 1'b0;
	logic [7:0]  sfr_rdata_o;
	logic        system_clock_out_o;
	logic        clock_source_o;
	logic        rd_d           = 1'b0;
	logic        rd_d2          = 1'b0;
	logic [15:0] ent;
	logic [15:0] exp_q[$];
	int          num_errors     = 0;
	int          tests_run      = 0;
	int          seed           = 92551;
	int          ext_per        = 5;

	sccs_clock_ctrl dut (
		.core_clk_i        (core_clk_i),
		.sys_rst_i         (sys_rst_i),
		.sfr_addr_i        (sfr_addr_i),
		.sfr_wr_i          (sfr_wr_i),
		.sfr_wdata_i       (sfr_wdata_i),
		.sfr_rd_i          (sfr_rd_i),
		.ext_osc_tick_i    (ext_osc_tick_i),
		.sfr_rdata_o       (sfr_rdata_o),
		.system_clock_out_o(system_clock_out_o),
		.clock_source_o    (clock_source_o)
	);

	always #2 core_clk_i = ~core_clk_i;

	// external oscillator: one pulse every ext_per core cycles
	always begin
		repeat (ext_per - 1) @(posedge core_clk_i);
		#1 ext_osc_tick_i = 1'b1;
		@(posedge core_clk_i);
		#1 ext_osc_tick_i = 1'b0;
	end

	task automatic chk(input string n, input logic [31:0] e,
			input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %0h seen %0h", n, e, g);
		end
	endtask : chk

	// ************************************************
	// read data watcher: oldest note against each answer
	// ************************************************
	always @(posedge core_clk_i) begin
		rd_d  <= sfr_rd_i;
		rd_d2 <= rd_d;
	end
	always @(negedge core_clk_i) begin
		if (rd_d2 === 1'b1 && exp_q.size() > 0) begin
			ent = exp_q.pop_front();
			if (ent[15:8] != 8'h00)
				chk("sfr_rdata_o", ent[7:0] & ent[15:8],
					sfr_rdata_o & ent[15:8]);
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr_i  = a;
		sfr_wdata_i = d;
		sfr_wr_i    = 1'b1;
		@(posedge core_clk_i);
		#1 sfr_wr_i = 1'b0;
	endtask : wr

	// mask 00 means a poll whose value is only returned
	task automatic rd(input logic [7:0] a, input logic [7:0] e,
			input logic [7:0] m, output logic [7:0] v);
		exp_q.push_back({m, e});
		sfr_addr_i = a;
		sfr_rd_i   = 1'b1;
		@(posedge core_clk_i);
		#1 sfr_rd_i = 1'b0;
		@(posedge core_clk_i);
		#1 v = sfr_rdata_o;
	endtask : rd

	// cycles from the next system clock pulse to the one after it
	task automatic per(output int p);
		int n;
		n = 0;
		while (system_clock_out_o !== 1'b1 && n < 5000) begin
			@(posedge core_clk_i);
			#1 n++;
		end
		p = 0;
		do begin
			@(posedge core_clk_i);
			#1 p++;
		end while (system_clock_out_o !== 1'b1 && p < 5000);
	endtask : per

	task automatic wait_rdy(input int lim);
		logic [7:0] v;
		int k;
		v = 8'h00;
		for (k = 0; k < lim && v[7] !== 1'b1; k++)
			rd(A_SEL, 8'h00, 8'h00, v);
		chk("divider ready flag", 1, v[7]);
	endtask : wait_rdy

	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test

	// about two and a half times the expected run length
	initial begin
		#160000;
		num_errors++;
		stop_test();
	end

	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		logic [7:0] v;
		int p, d, t, s, lo, hi;
		repeat (3) @(posedge core_clk_i);
		#1 sys_rst_i = 1'b0;
		rd(A_SEL, 8'h00, 8'h7f, v);
		rd(A_CTL, 8'h00, 8'hff, v);
		rd(A_TRM, {1'b0, sccs_pkg::TRIM_RESET}, 8'hff, v);
		rd(8'h00, 8'h00, 8'hff, v);
		per(p);
		chk("reset postscale", NOM * 8, p);
		wait_rdy(100);
		$display("reset test done");
		for (t = 0; t < 4; t++) begin
			wr(A_CTL, 8'(3 - t));
			per(p);
			per(p);
			chk("postscale period", NOM << t, p);
		end
		wr(A_CTL, 8'h03);
		$display("postscale test done");
		// write just after a pulse so no boundary lands before the read
		for (d = 0; d < 8; d++) begin
			per(p);
			wr(A_SEL, 8'(d << 4));
			rd(A_SEL, ((d == 0) ? 8'h80 : 8'h00) | 8'(d << 4),
				8'hff, v);
			wait_rdy(700);
			per(p);
			chk("divided period", NOM << d, p);
		end
		per(p);
		wr(A_SEL, 8'h00); // divide by 1 again
		wait_rdy(700);
		$display("divider test done");
		for (t = 0; t < 3; t++) begin
			d = (t == 1) ? {$random(seed)} % 128 : (t == 0 ? 0 : 127);
			wr(A_TRM, 8'(d) | 8'h80);
			rd(A_TRM, 8'(d), 8'hff, v);
			per(p);
			per(p);
			chk("trim period", sccs_pkg::OSC_MIN_CYC + d, p);
		end
		wr(A_TRM, {1'b0, sccs_pkg::TRIM_RESET});
		$display("trim test done");
		@(posedge core_clk_i);
		#1 wr(A_CTL, 8'hff);
		rd(A_CTL, 8'h0b, 8'hff, v);
		per(p);
		s = 0;
		lo = 9999;
		hi = 0;
		repeat (sccs_pkg::SS_WAVE_TICKS) begin
			per(p);
			s += p;
			lo = (p < lo) ? p : lo;
			hi = (p > hi) ? p : hi;
		end
		chk("dither wave sum", NOM * sccs_pkg::SS_WAVE_TICKS, s);
		chk("dither swing", 6, hi - lo);
		wr(A_CTL, 8'h03);
		$display("spread spectrum test done");
		ext_per = 3 + {$random(seed)} % 7;
		repeat (20) @(posedge core_clk_i);
		#1 wr(A_SEL, 8'h01);
		p = 0;
		while (clock_source_o !== 1'b1 && p < 100) begin
			@(posedge core_clk_i);
			#1 p++;
		end
		chk("switch on pulse", 1, system_clock_out_o);
		chk("switch in time", 1, p < 60);
		per(p);
		per(p);
		chk("external period", ext_per, p);
		rd(A_SEL, 8'h81, 8'hff, v);
		wr(A_SEL, 8'h02);
		rd(A_SEL, 8'h82, 8'hff, v);
		repeat (40) @(posedge core_clk_i);
		#1 chk("reserved source", 1, clock_source_o);
		wr(A_SEL, 8'h00);
		repeat (60) @(posedge core_clk_i);
		#1 chk("back to internal", 0, clock_source_o);
		per(p);
		chk("internal period", NOM, p);
		$display("source test done");
		stop_test();
	end
endmodule : tb
